// ===== rtl/core_interrupt_logic.sv
// interrupt flags, enables, vectoring and wake-up of the core, with an Avalon-MM slave
// Operation
// - control bit 7 is global enable; clear blocks all, reset clears it
// - each core source has its own enable bit in the control register
// - return-from-interrupt sets global enable so pending requests are taken
// - peripheral group enable gates comparator and parallel-port requests
// - peripheral flags and enables live in their own two registers
// - entry clears global enable, pushes return address, loads vector 0004h
// - pin and port-change events reach the vector in three or four cycles
// - flags set on their event whatever the enable bits say
// - clearing global enable ignores requests next cycle, which runs as no-op
// - pin interrupt edge: rising when option bit 6 set, else falling
// - valid pin edge sets pin flag at control bit 1
// - control bit 4 enables the pin interrupt
// - enabled flag wakes from sleep; global enable then picks vector or inline
// - timer roll-over FFh to 00h sets bit 2; bit 5 enables it
// - change on any of port pins 7:4 sets control bit 0
// - parallel-port source exists only in variants that have the port
// - only the return address is saved on entry; software saves the rest
// - pin flag may set in any cycle an edge is seen
`timescale 1ns/1ps
`default_nettype none

module core_interrupt_logic #(
    parameter bit HAS_PARALLEL_PORT = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [9:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire irq_logic_pkg::event_in_type events,
    input wire irq_logic_pkg::core_in_type core_in,
    output irq_logic_pkg::core_out_type core_out
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        irq_logic_pkg::ctl_state_type st;
        logic [7:0] irq_control_reg;
        logic [7:0] pflag;
        logic [7:0] pen;
        logic [7:0] option;
        logic ext_prev;
        logic [3:0] port_prev;
        logic [7:0] tmr_prev;
        logic ack;
        logic [31:0] rdata;
        logic blk;
        logic wake;
        logic [12:0] ret_pc;
    } state_type;

    state_type q;
    state_type d;

    logic [7:0] index;
    logic rd_go;
    logic wr_go;
    logic wr_lane;
    logic ext_edge;
    logic port_chg;
    logic tmr_ovf;
    logic cmp_ev;
    logic pport_ev;
    logic [7:0] pmask;
    logic core_any;
    logic periph_any;
    logic irq_req;

    // ------------------------------------------------------------
    // bus decode: one wait state, answer at the second edge
    // ------------------------------------------------------------
    assign index = avs_address[9:2];
    assign rd_go = avs_read & ~q.ack;
    assign wr_go = avs_write & q.ack;
    assign wr_lane = wr_go & avs_byteenable[0];
    assign avs_waitrequest = (avs_read | avs_write) & ~q.ack;
    assign avs_readdata = q.rdata;

    // ------------------------------------------------------------
    // event detection
    // ------------------------------------------------------------
    // inputs are synchronous, so one previous sample is enough for edges
    assign ext_edge = q.option[irq_logic_pkg::BIT_EDGE_POL] ?
        (events.ext_irq_pin & ~q.ext_prev) :
        (~events.ext_irq_pin & q.ext_prev);
    assign port_chg = |(events.port_hi_pins ^ q.port_prev);
    assign tmr_ovf = (q.tmr_prev == irq_logic_pkg::TMR_TOP) &&
        (events.timer_count == irq_logic_pkg::TMR_ZERO);
    assign cmp_ev = events.comparator_event;
    assign pport_ev = events.parallel_port_event & HAS_PARALLEL_PORT;
    // without the port its flag and enable bits are unimplemented
    assign pmask = HAS_PARALLEL_PORT ? 8'hC0 : 8'h40;

    // ------------------------------------------------------------
    // request to the core
    // ------------------------------------------------------------
    assign core_any =
        (q.irq_control_reg[irq_logic_pkg::BIT_EXT_FLAG] & q.irq_control_reg[irq_logic_pkg::BIT_EXT_EN]) |
        (q.irq_control_reg[irq_logic_pkg::BIT_TIMER_FLAG] & q.irq_control_reg[irq_logic_pkg::BIT_TIMER_EN]) |
        (q.irq_control_reg[irq_logic_pkg::BIT_PIN_CHG_FLAG] &
         q.irq_control_reg[irq_logic_pkg::BIT_PIN_CHG_EN]);
    assign periph_any = q.irq_control_reg[irq_logic_pkg::BIT_PERIPH_GRP_EN] &
        (|(q.pflag & q.pen));
    assign irq_req = q.irq_control_reg[irq_logic_pkg::BIT_GLOBAL_EN] &
        (core_any | periph_any);

    always_comb begin
        core_out.irq_request = irq_req;
        core_out.vector_load = (q.st == irq_logic_pkg::CTL_ENTRY);
        core_out.vector_pc = irq_logic_pkg::IRQ_VECTOR;
        // only the return address goes to the stack; W and status stay with software
        core_out.stack_push = (q.st == irq_logic_pkg::CTL_ENTRY);
        core_out.stack_data = q.ret_pc;
        core_out.force_nop = q.blk;
        core_out.wake_up = q.wake;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.blk = 1'b0;
        d.ext_prev = events.ext_irq_pin;
        d.port_prev = events.port_hi_pins;
        d.tmr_prev = events.timer_count;
        d.ack = (avs_read | avs_write) & ~q.ack;
        if (rd_go) begin
            case (index)
                irq_logic_pkg::IDX_IRQ_CONTROL: d.rdata = {24'h000000, q.irq_control_reg};
                irq_logic_pkg::IDX_PERIPH_FLAG: d.rdata = {24'h000000, q.pflag};
                irq_logic_pkg::IDX_PERIPH_ENABLE: d.rdata = {24'h000000, q.pen};
                irq_logic_pkg::IDX_OPTION: d.rdata = {24'h000000, q.option};
                default: d.rdata = 32'h00000000;
            endcase
        end
        if (wr_lane) begin
            case (index)
                irq_logic_pkg::IDX_IRQ_CONTROL: begin
                    d.irq_control_reg = avs_writedata[7:0];
                    // a write that drops global enable stands in for the disabling instruction
                    d.blk = q.irq_control_reg[irq_logic_pkg::BIT_GLOBAL_EN] &
                        ~avs_writedata[irq_logic_pkg::BIT_GLOBAL_EN];
                end
                irq_logic_pkg::IDX_PERIPH_FLAG: d.pflag = avs_writedata[7:0] & pmask;
                irq_logic_pkg::IDX_PERIPH_ENABLE: d.pen = avs_writedata[7:0] & pmask;
                irq_logic_pkg::IDX_OPTION: d.option = avs_writedata[7:0];
                default: d.option = q.option;
            endcase
        end
        if (core_in.return_from_irq_instr) begin
            d.irq_control_reg[irq_logic_pkg::BIT_GLOBAL_EN] = 1'b1;
        end
        case (q.st)
            irq_logic_pkg::CTL_IDLE: begin
                if (irq_req) begin
                    d.st = irq_logic_pkg::CTL_PEND;
                end
            end
            irq_logic_pkg::CTL_PEND: begin
                if (!irq_req) begin
                    d.st = irq_logic_pkg::CTL_IDLE;
                end else if (core_in.instr_boundary && !q.blk) begin
                    d.st = irq_logic_pkg::CTL_ENTRY;
                    d.irq_control_reg[irq_logic_pkg::BIT_GLOBAL_EN] = 1'b0;
                    d.ret_pc = core_in.return_pc;
                end
            end
            irq_logic_pkg::CTL_ENTRY: d.st = irq_logic_pkg::CTL_IDLE;
            default: d.st = irq_logic_pkg::CTL_IDLE;
        endcase
        // events are ORed in last so a same-cycle clear never loses them
        if (ext_edge) begin
            d.irq_control_reg[irq_logic_pkg::BIT_EXT_FLAG] = 1'b1;
        end
        if (tmr_ovf) begin
            d.irq_control_reg[irq_logic_pkg::BIT_TIMER_FLAG] = 1'b1;
        end
        if (port_chg) begin
            d.irq_control_reg[irq_logic_pkg::BIT_PIN_CHG_FLAG] = 1'b1;
        end
        if (cmp_ev) begin
            d.pflag[irq_logic_pkg::BIT_CMP] = 1'b1;
        end
        if (pport_ev) begin
            d.pflag[irq_logic_pkg::BIT_PPORT] = 1'b1;
        end
        // wake ignores global enable; the core then vectors or runs on in line
        d.wake = core_in.sleep_active & (core_any | periph_any);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            q.st <= irq_logic_pkg::CTL_IDLE;
            q.irq_control_reg <= irq_logic_pkg::RST_IRQ_CONTROL;
            q.pflag <= irq_logic_pkg::RST_PERIPH;
            q.pen <= irq_logic_pkg::RST_PERIPH;
            q.option <= irq_logic_pkg::RST_OPTION;
            q.ext_prev <= 1'b0;
            q.port_prev <= 4'h0;
            q.tmr_prev <= 8'h00;
            q.ack <= 1'b0;
            q.rdata <= 32'h00000000;
            q.blk <= 1'b0;
            q.wake <= 1'b0;
            q.ret_pc <= 13'h0000;
        end else if (clk_en) begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    AST_NO_REQ_WITHOUT_GIE: assert property (@(posedge clk_sys) disable iff (!rstn)
        !q.irq_control_reg[irq_logic_pkg::BIT_GLOBAL_EN] |-> !core_out.irq_request)
        else $error("request raised with global enable clear");

    AST_PERIPH_GATED: assert property (@(posedge clk_sys) disable iff (!rstn)
        (!q.irq_control_reg[irq_logic_pkg::BIT_PERIPH_GRP_EN] && !core_any) |-> !core_out.irq_request)
        else $error("peripheral request passed with group enable clear");

    AST_RETURN_SETS_GIE: assert property (@(posedge clk_sys) disable iff (!rstn)
        (clk_en && core_in.return_from_irq_instr && q.st != irq_logic_pkg::CTL_PEND)
        |=> q.irq_control_reg[irq_logic_pkg::BIT_GLOBAL_EN])
        else $error("return from interrupt did not set global enable");

    AST_ENTRY_CLEARS_GIE: assert property (@(posedge clk_sys) disable iff (!rstn)
        core_out.vector_load |-> (core_out.stack_push &&
        !q.irq_control_reg[irq_logic_pkg::BIT_GLOBAL_EN] && core_out.stack_data == $past(core_in.return_pc)))
        else $error("entry without stack push or with global enable set");

    AST_LATENCY: assert property (@(posedge clk_sys) disable iff (!rstn)
        (clk_en && q.st == irq_logic_pkg::CTL_PEND && irq_req &&
         core_in.instr_boundary && !q.blk) |=> core_out.vector_load)
        else $error("pending request not vectored at boundary");

    AST_NOP_BLOCKS: assert property (@(posedge clk_sys) disable iff (!rstn)
        (core_out.force_nop && q.st != irq_logic_pkg::CTL_ENTRY) |=> !core_out.vector_load)
        else $error("vectored in the cycle after global enable was cleared");

    AST_EXT_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
        (clk_en && ext_edge) |=> q.irq_control_reg[irq_logic_pkg::BIT_EXT_FLAG])
        else $error("pin edge did not set pin flag");

    AST_TIMER_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
        (clk_en && $past(events.timer_count) == 8'hFF && events.timer_count == 8'h00
         && q.tmr_prev == 8'hFF) |=> q.irq_control_reg[irq_logic_pkg::BIT_TIMER_FLAG])
        else $error("timer roll-over did not set timer flag");

    AST_PORT_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!rstn)
        (clk_en && port_chg) |=> q.irq_control_reg[irq_logic_pkg::BIT_PIN_CHG_FLAG])
        else $error("port change did not set its flag");

    AST_FLAG_HOLDS: assert property (@(posedge clk_sys) disable iff (!rstn)
        (clk_en && q.irq_control_reg[irq_logic_pkg::BIT_EXT_FLAG] &&
         !(wr_lane && index == irq_logic_pkg::IDX_IRQ_CONTROL))
        |=> q.irq_control_reg[irq_logic_pkg::BIT_EXT_FLAG])
        else $error("pin flag dropped without a write");

endmodule : core_interrupt_logic

`default_nettype wire

// ===== rtl/irq_logic_pkg.sv
// shared constants and carrier types of the core interrupt logic
package irq_logic_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_IRQ_CONTROL = 8'h0B;
    localparam logic [7:0] IDX_PERIPH_FLAG = 8'h0C;
    localparam logic [7:0] IDX_OPTION = 8'h81;
    localparam logic [7:0] IDX_PERIPH_ENABLE = 8'h8C;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int BIT_GLOBAL_EN = 7;
    localparam int BIT_PERIPH_GRP_EN = 6;
    localparam int BIT_TIMER_EN = 5;
    localparam int BIT_EXT_EN = 4;
    localparam int BIT_PIN_CHG_EN = 3;
    localparam int BIT_TIMER_FLAG = 2;
    localparam int BIT_EXT_FLAG = 1;
    localparam int BIT_PIN_CHG_FLAG = 0;
    localparam int BIT_PPORT = 7;
    localparam int BIT_CMP = 6;
    localparam int BIT_EDGE_POL = 6;

    // ------------------------------------------------------------
    // reset values and fixed numbers
    // ------------------------------------------------------------
    localparam logic [7:0] RST_IRQ_CONTROL = 8'h00;
    localparam logic [7:0] RST_PERIPH = 8'h00;
    localparam logic [7:0] RST_OPTION = 8'hFF;
    localparam logic [7:0] TMR_TOP = 8'hFF;
    localparam logic [7:0] TMR_ZERO = 8'h00;
    localparam logic [12:0] IRQ_VECTOR = 13'h0004;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        CTL_IDLE = 2'b00,
        CTL_PEND = 2'b01,
        CTL_ENTRY = 2'b11
    } ctl_state_type;

    typedef struct packed {
        logic ext_irq_pin;
        logic [3:0] port_hi_pins;
        logic [7:0] timer_count;
        logic comparator_event;
        logic parallel_port_event;
    } event_in_type;

    typedef struct packed {
        logic instr_boundary;
        logic return_from_irq_instr;
        logic sleep_active;
        logic [12:0] return_pc;
    } core_in_type;

    typedef struct packed {
        logic irq_request;
        logic vector_load;
        logic [12:0] vector_pc;
        logic stack_push;
        logic [12:0] stack_data;
        logic force_nop;
        logic wake_up;
    } core_out_type;

endpackage : irq_logic_pkg

// ===== tb/core_model.sv
// behavioural processor core facing the interrupt logic
`timescale 1ns/1ps
`default_nettype none

module core_model #(
    parameter logic [12:0] RET_PC = 13'h0ABC
) (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic take_en,
    input wire logic ret_req,
    input wire logic sleep_req,
    input wire irq_logic_pkg::core_out_type core_out,
    output irq_logic_pkg::core_in_type core_in,
    output logic [7:0] entry_count
);
    // ------------------------------------------------------------
    // instruction stream
    // ------------------------------------------------------------
    // boundaries only while allowed, so a request can be held pending
    always_comb begin
        core_in.instr_boundary = take_en;
        core_in.return_from_irq_instr = ret_req;
        core_in.sleep_active = sleep_req;
        core_in.return_pc = RET_PC;
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            entry_count <= 8'h00;
        end else if (core_out.vector_load) begin
            entry_count <= entry_count + 8'h01;
        end
    end
endmodule : core_model
`default_nettype wire

// ===== tb/testbench.sv
// self-checking bench of the core interrupt logic
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk_sys;
    logic rstn = 1'b0;
    logic [9:0] avs_address = 10'h000;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    irq_logic_pkg::event_in_type ev = '0;
    irq_logic_pkg::core_in_type core_in;
    irq_logic_pkg::core_out_type core_out;
    logic clk_en = 1'b1;
    logic [31:0] scratch;
    logic take_en = 1'b0;
    logic ret_req = 1'b0;
    logic sleep_req = 1'b0;
    logic [7:0] entry_count;
    int err_total = 0;
    int tests_run = 0;
    int cycles = 0;
    int nop_count = 0;
    int n;

    core_interrupt_logic i_core_interrupt_logic (
        .clk_sys(clk_sys), .rstn(rstn), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .events(ev), .core_in(core_in), .core_out(core_out)
    );

    core_model i_core_model (
        .clk_sys(clk_sys), .rstn(rstn), .take_en(take_en), .ret_req(ret_req),
        .sleep_req(sleep_req), .core_out(core_out), .core_in(core_in),
        .entry_count(entry_count)
    );

    // ------------------------------------------------------------
    // clock, watchdog, monitors
    // ------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // whole run needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles++;
        if (core_out.force_nop === 1'b1) nop_count++;
        if (cycles == 5000) begin
            err_total++;
            results();
        end
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // holds the request until waitrequest is low at a rising edge; both are
    // looked at mid-cycle, where they are settled and stand through that edge
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                       input logic [3:0] be, output logic [31:0] rdata);
        logic ws;
        @(posedge clk_sys);
        avs_address <= {idx, 2'b00};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h000000, wd};
        avs_byteenable <= be;
        do begin
            @(negedge clk_sys);
            ws = avs_waitrequest;
            rdata = avs_readdata;
            @(posedge clk_sys);
        end while (ws !== 1'b0);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        logic [31:0] d;
        bus(1'b1, idx, wd, 4'hF, d);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] d;
        bus(1'b0, idx, 8'h00, 4'hF, d);
        check(d, {24'h000000, exp});
    endtask : rd

    task automatic results();
        $display("comparisons %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        rstn <= 1'b1;
        rd(irq_logic_pkg::IDX_IRQ_CONTROL, irq_logic_pkg::RST_IRQ_CONTROL);
        rd(irq_logic_pkg::IDX_PERIPH_FLAG, irq_logic_pkg::RST_PERIPH);
        rd(irq_logic_pkg::IDX_PERIPH_ENABLE, irq_logic_pkg::RST_PERIPH);
        rd(irq_logic_pkg::IDX_OPTION, irq_logic_pkg::RST_OPTION);
        rd(8'h55, 8'h00);
        // flags rise with every enable clear
        @(posedge clk_sys) ev.ext_irq_pin <= 1'b1;
        rd(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h02);
        wr(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h00);
        wr(irq_logic_pkg::IDX_OPTION, 8'hBF);
        @(posedge clk_sys) ev.ext_irq_pin <= 1'b0;
        rd(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h02);
        wr(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h00);
        @(posedge clk_sys) ev.port_hi_pins <= 4'h8;
        rd(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h01);
        wr(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h00);
        // a climb from 00h to FFh is no roll-over
        @(posedge clk_sys) ev.timer_count <= 8'hFF;
        rd(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h00);
        @(posedge clk_sys) ev.timer_count <= 8'h00;
        rd(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h04);
        wr(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h00);
        @(posedge clk_sys) ev.comparator_event <= 1'b1;
        @(posedge clk_sys) ev.comparator_event <= 1'b0;
        ev.parallel_port_event <= 1'b1;
        @(posedge clk_sys) ev.parallel_port_event <= 1'b0;
        rd(irq_logic_pkg::IDX_PERIPH_FLAG, 8'hC0);
        bus(1'b1, irq_logic_pkg::IDX_IRQ_CONTROL, 8'hFF, 4'h0, scratch);
        rd(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h00);
        // peripheral gating with boundaries withheld
        wr(irq_logic_pkg::IDX_PERIPH_ENABLE, 8'hC0);
        wr(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h80);
        #1 check(core_out.irq_request, 32'h0);
        wr(irq_logic_pkg::IDX_IRQ_CONTROL, 8'hC0);
        #1 check(core_out.irq_request, 32'h1);
        wr(irq_logic_pkg::IDX_PERIPH_ENABLE, 8'h00);
        #1 check(core_out.irq_request, 32'h0);
        wr(irq_logic_pkg::IDX_PERIPH_FLAG, 8'h00);
        wr(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h00);
        repeat (2) @(posedge clk_sys);
        check(32'(nop_count), 32'h1);
        // pin edge to vector
        take_en <= 1'b1;
        wr(irq_logic_pkg::IDX_OPTION, 8'hFF);
        wr(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h90);
        @(posedge clk_sys) ev.ext_irq_pin <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            #1 n++;
        end while (core_out.vector_load !== 1'b1 && n < 10);
        check(32'(n >= 3 && n <= 4), 32'h1);
        check(core_out.stack_data, 32'h0ABC);
        check(core_out.vector_pc, irq_logic_pkg::IRQ_VECTOR);
        check(core_out.stack_push, 32'h1);
        check(core_out.irq_request, 32'h0);
        rd(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h12);
        // return with the flag left set: the request is taken again
        @(posedge clk_sys) ret_req <= 1'b1;
        @(posedge clk_sys) ret_req <= 1'b0;
        repeat (6) @(posedge clk_sys);
        check(entry_count, 32'h2);
        wr(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h10);
        @(posedge clk_sys) ret_req <= 1'b1;
        @(posedge clk_sys) ret_req <= 1'b0;
        rd(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h90);
        wr(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h10);
        // wake from sleep with global enable clear
        take_en <= 1'b0;
        sleep_req <= 1'b1;
        wr(irq_logic_pkg::IDX_OPTION, 8'hBF);
        @(posedge clk_sys) ev.ext_irq_pin <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 check(core_out.wake_up, 32'h1);
        check(entry_count, 32'h2);
        wr(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h02);
        repeat (2) @(posedge clk_sys);
        #1 check(core_out.wake_up, 32'h0);
        // a return while the clock enable is low must change nothing
        @(posedge clk_sys) clk_en <= 1'b0;
        @(posedge clk_sys) ret_req <= 1'b1;
        @(posedge clk_sys) ret_req <= 1'b0;
        clk_en <= 1'b1;
        rd(irq_logic_pkg::IDX_IRQ_CONTROL, 8'h02);
        results();
    end
endmodule : testbench
`default_nettype wire
